// file: fsp_host_model.sv
`timescale 1ns/1ns
module fsp_host_model
(
	input wire logic ref_clk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	logic [31:0] rdata;
	logic err;
	// ==========================================================
	// idle bus
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// one transfer; a free edge first so psel is never driven twice in a step
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// no cycle count assumed: only the bench watchdog ends a hung wait
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released address and data show the inverse, never a stale copy; pwrite keeps its value
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : fsp_host_model

// file: fsp_pkg.sv
package fsp_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int UNLOCK_GAP_NS = 1000;
	// least spacing between unlock attempts, rounded up
	localparam int UNLOCK_GAP_CYC = (UNLOCK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UNLOCK_TIME_NS = 1000;
	// unlock completion time, rounded down
	localparam int UNLOCK_TIME_CYC = UNLOCK_TIME_NS / CLK_PERIOD_NS;
	localparam int POLL_CYC = 4;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_SEL = 8'h04;
	localparam logic [7:0] OFF_SECT = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_PWD = 8'h10;
	localparam logic [7:0] OFF_UBUF = 8'h20;

	// ==========================================================
	// command register fields and opcodes
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_SECT_LSB = 8;
	localparam logic [3:0] OP_PROT_ENTER = 4'h1;
	localparam logic [3:0] OP_PROT_EXIT = 4'h2;
	localparam logic [3:0] OP_DYN_SET = 4'h3;
	localparam logic [3:0] OP_DYN_CLR = 4'h4;
	localparam logic [3:0] OP_PERS_PROG = 4'h5;
	localparam logic [3:0] OP_PERS_ERASE = 4'h6;
	localparam logic [3:0] OP_FREEZE_SET = 4'h7;
	localparam logic [3:0] OP_PWD_UNLOCK = 4'h8;
	localparam logic [3:0] OP_PWD_MODE_LOCK = 4'h9;
	localparam logic [3:0] OP_PERS_MODE_LOCK = 4'ha;
	localparam logic [3:0] OP_ARRAY_PE = 4'hb;

	// ==========================================================
	// status register bit positions
	localparam int ST_FREEZE = 0;
	localparam int ST_PWD_MODE = 1;
	localparam int ST_PERS_MODE = 2;
	localparam int ST_PROT_MODE = 3;
	localparam int ST_UNLOCK_BUSY = 4;
	localparam int ST_LOCKOUT = 5;
	localparam int ST_WP_PIN = 6;
	localparam int ST_INHIBIT = 7;
	localparam int ST_REFUSED = 8;
	localparam int ST_PWD_TIMEOUT = 9;
	localparam int ST_UNLOCK_FAIL = 10;

	// sector status bit positions
	localparam int SS_VOLATILE = 0;
	localparam int SS_PERSISTENT = 1;
	localparam int SS_PROTECTED = 2;
	localparam int SS_WP_FORCED = 3;

	// ==========================================================
	// reset values
	localparam logic RST_FREEZE_OPEN = 1'b1;
	localparam logic [15:0] RST_PWD_WORD = 16'hffff;
	localparam logic RST_PERS_BIT = 1'b1;

endpackage : fsp_pkg

// file: fsp_protect.sv
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ns
module fsp_protect
	import fsp_pkg::*;
#(
	parameter int N_SECT = 16
)
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic pwr_on_reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic write_protect_accel_pin_n,
	input wire logic supply_lockout_level,
	input wire logic we_n,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic volatile_lock_boot_opt,
	output logic array_pe_go,
	output logic [7:0] array_pe_sector,
	output logic status_poll,
	output logic first_bank_block,
	output logic global_persistent_freeze
);

	localparam int SW = (N_SECT > 1) ? $clog2(N_SECT) : 1;

	// ==========================================================
	// elaboration checks
	initial
	begin
		if (N_SECT < 4 || N_SECT > 256)
			$error("N_SECT must lie in 4..256");
		if (UNLOCK_GAP_CYC > 255 || UNLOCK_TIME_CYC > 255 || UNLOCK_TIME_CYC < 1)
			$error("timing counts do not fit 8-bit counters");
	end

	// ==========================================================
	// helpers
	// four outermost boot sectors: two at each end
	function automatic logic fsp_outer(input logic [SW-1:0] idx);
		fsp_outer = (idx < SW'(2)) || (idx >= SW'(N_SECT - 2));
	endfunction : fsp_outer

	function automatic logic fsp_bit_prot(input logic pers, input logic vol);
		fsp_bit_prot = !pers || !vol;
	endfunction : fsp_bit_prot

	function automatic logic fsp_mapped(input logic [7:0] a);
		fsp_mapped = (a[1:0] == 2'b00) && (a <= (OFF_UBUF + 8'h0c));
	endfunction : fsp_mapped

	// ==========================================================
	// pin synchronisers
	// order: wp_n, lockout, we_n, ce_n, oe_n, boot option
	logic [5:0] pin_meta_ff, pin_sync_ff;
	always_ff @(posedge ref_clk)
	begin
		pin_meta_ff <= {write_protect_accel_pin_n, supply_lockout_level, we_n, ce_n, oe_n, volatile_lock_boot_opt};
		pin_sync_ff <= pin_meta_ff;
	end
	logic s_wp_n, s_lockout, s_we_n, s_ce_n, s_oe_n, s_boot_opt;
	assign {s_wp_n, s_lockout, s_we_n, s_ce_n, s_oe_n, s_boot_opt} = pin_sync_ff;
	logic rst_any;
	assign rst_any = reset || pwr_on_reset;
	// ==========================================================
	// power-up write inhibit
	logic inhibit_ff;
	// power-up inhibit
	// held until we_n or ce_n is seen high or oe_n is seen low, so a write enable rising edge starts nothing
	always_ff @(posedge ref_clk)
	begin
		if (rst_any)
			inhibit_ff <= 1'b1;
		else if (s_we_n || s_ce_n || !s_oe_n)
			inhibit_ff <= 1'b0;
	end

	// ==========================================================
	// apb slave: one wait state so every output is a flip-flop
	logic pready_ff, pslverr_ff, wr_blocked, acc_done, wr_go;
	logic [31:0] prdata_ff, rd_data;
	assign wr_blocked = s_lockout || inhibit_ff;
	assign acc_done = psel && penable && pready_ff;
	assign wr_go = acc_done && pwrite && fsp_mapped(paddr) && !wr_blocked;

	always_ff @(posedge ref_clk)
	begin
		if (rst_any)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end
		else
		begin
			pready_ff <= psel && penable && !pready_ff;
			pslverr_ff <= psel && penable && !pready_ff
				&& (!fsp_mapped(paddr) || (pwrite && wr_blocked));
			prdata_ff <= (psel && penable && !pready_ff && !pwrite) ? rd_data : 32'h0;
		end
	end

	// ==========================================================
	// protection state
	logic [N_SECT-1:0] vol_ff, pers_ff;
	logic freeze_ff, pwd_mode_ff, pers_mode_ff, prot_mode_ff;
	logic [15:0] pwd_ff [4];
	logic [15:0] ubuf_ff [4];
	logic [SW-1:0] sel_ff;
	logic [7:0] gap_cnt_ff, unlock_cnt_ff, pe_sect_ff;
	logic [2:0] poll_cnt_ff;
	logic refused_ff, pwd_to_ff, ufail_ff, pe_go_ff, poll_ff;
	// command decode
	logic cmd_go, cmd_needs_mode, cmd_ok, pwd_match;
	logic [3:0] cmd_op;
	logic [SW-1:0] cmd_sect;
	logic [1:0] wsel;
	assign cmd_go = wr_go && (paddr == OFF_CMD);
	assign cmd_op = pwdata[CMD_OP_LSB +: 4];
	assign cmd_sect = pwdata[CMD_SECT_LSB +: SW];
	assign cmd_needs_mode = (cmd_op != OP_PROT_ENTER) && (cmd_op != OP_ARRAY_PE);
	assign cmd_ok = cmd_go && (!cmd_needs_mode || prot_mode_ff);
	// word select from low word address bits
	assign wsel = paddr[3:2];
	assign pwd_match = {ubuf_ff[3], ubuf_ff[2], ubuf_ff[1], ubuf_ff[0]}
		== {pwd_ff[3], pwd_ff[2], pwd_ff[1], pwd_ff[0]};
	logic unlock_try, unlock_take, pers_blocked, pe_prot, pwd_wr, pwd_bad;
	assign unlock_try = cmd_ok && (cmd_op == OP_PWD_UNLOCK);
	// attempts inside the guard interval are refused
	assign unlock_take = unlock_try && pwd_mode_ff && (gap_cnt_ff == 8'h0) && (unlock_cnt_ff == 8'h0);
	assign pers_blocked = !freeze_ff;
	// pin low overrides the bit scheme on outer sectors
	assign pe_prot = fsp_bit_prot(pers_ff[cmd_sect], vol_ff[cmd_sect])
		|| (!s_wp_n && fsp_outer(cmd_sect));
	// password frozen once its mode lock is set
	assign pwd_wr = wr_go && (paddr[7:4] == OFF_PWD[7:4]) && prot_mode_ff && !pwd_mode_ff;
	assign pwd_bad = pwd_wr && |(pwdata[15:0] & ~pwd_ff[wsel]);

	// volatile locks and sector select
	always_ff @(posedge ref_clk)
	begin
		if (rst_any)
		begin
			vol_ff <= {N_SECT{s_boot_opt}};
			sel_ff <= '0;
		end
		else
		begin
			if (wr_go && paddr == OFF_SEL)
				sel_ff <= pwdata[SW-1:0];
			if (cmd_ok && cmd_op == OP_DYN_SET)
				vol_ff[cmd_sect] <= 1'b0;
			else if (cmd_ok && cmd_op == OP_DYN_CLR)
				vol_ff[cmd_sect] <= 1'b1;
		end
	end

	// non-volatile state survives reset; only power-on initialises it
	always_ff @(posedge ref_clk)
	begin
		if (pwr_on_reset)
		begin
			pers_ff <= {N_SECT{RST_PERS_BIT}};
			pwd_mode_ff <= 1'b0;
			pers_mode_ff <= 1'b0;
			for (int i = 0; i < 4; i++)
				pwd_ff[i] <= RST_PWD_WORD;
		end
		else
		begin
			// program only while freeze is open
			if (cmd_ok && cmd_op == OP_PERS_PROG && !pers_blocked)
				pers_ff[cmd_sect] <= 1'b0;
			else if (cmd_ok && cmd_op == OP_PERS_ERASE && !pers_blocked)
				pers_ff <= {N_SECT{1'b1}};
			// the two mode locks exclude each other
			if (cmd_ok && cmd_op == OP_PWD_MODE_LOCK && !pers_mode_ff)
				pwd_mode_ff <= 1'b1;
			if (cmd_ok && cmd_op == OP_PERS_MODE_LOCK && !pwd_mode_ff)
				pers_mode_ff <= 1'b1;
			if (pwd_wr)
				pwd_ff[wsel] <= pwd_ff[wsel] & pwdata[15:0];
		end
	end

	// global freeze and entry mode
	always_ff @(posedge ref_clk)
	begin
		if (rst_any)
		begin
			// password mode closes freeze at reset
			freeze_ff <= pwr_on_reset ? RST_FREEZE_OPEN : !pwd_mode_ff;
			prot_mode_ff <= 1'b0;
		end
		else
		begin
			// freeze set closes all persistent locks
			if (cmd_ok && cmd_op == OP_FREEZE_SET)
				freeze_ff <= 1'b0;
			// open after the unlock time elapses
			else if (unlock_cnt_ff == 8'h1 && !s_lockout)
				freeze_ff <= 1'b1;
			// lockout drops back to array read
			if (s_lockout)
				prot_mode_ff <= 1'b0;
			else if (cmd_go && cmd_op == OP_PROT_ENTER)
				prot_mode_ff <= 1'b1;
			else if (cmd_ok && cmd_op == OP_PROT_EXIT)
				prot_mode_ff <= 1'b0;
		end
	end

	// unlock buffer, guard and completion counters
	always_ff @(posedge ref_clk)
	begin
		if (rst_any)
		begin
			gap_cnt_ff <= 8'h0;
			unlock_cnt_ff <= 8'h0;
			for (int i = 0; i < 4; i++)
				ubuf_ff[i] <= 16'h0;
		end
		else
		begin
			if (wr_go && paddr[7:4] == OFF_UBUF[7:4])
				ubuf_ff[wsel] <= pwdata[15:0];
			// guard interval restarts on every accepted attempt
			if (unlock_take)
				gap_cnt_ff <= 8'(UNLOCK_GAP_CYC);
			else if (gap_cnt_ff != 8'h0)
				gap_cnt_ff <= gap_cnt_ff - 8'h1;
			// only a matching password reopens the freeze
			if (s_lockout)
				unlock_cnt_ff <= 8'h0;
			else if (unlock_take && pwd_match)
				unlock_cnt_ff <= 8'(UNLOCK_TIME_CYC);
			else if (unlock_cnt_ff != 8'h0)
				unlock_cnt_ff <= unlock_cnt_ff - 8'h1;
		end
	end

	// sticky error flags, write one to clear; a new event beats the clear
	logic st_clr;
	assign st_clr = wr_go && paddr == OFF_STATUS;
	always_ff @(posedge ref_clk)
	begin
		if (rst_any)
		begin
			refused_ff <= 1'b0;
			pwd_to_ff <= 1'b0;
			ufail_ff <= 1'b0;
		end
		else
		begin
			if ((cmd_go && !cmd_ok) || (unlock_try && !unlock_take)
				|| (cmd_ok && (cmd_op == OP_PERS_PROG || cmd_op == OP_PERS_ERASE) && pers_blocked))
				refused_ff <= 1'b1;
			else if (st_clr && pwdata[ST_REFUSED])
				refused_ff <= 1'b0;
			if (pwd_bad)
				pwd_to_ff <= 1'b1;
			else if (st_clr && pwdata[ST_PWD_TIMEOUT])
				pwd_to_ff <= 1'b0;
			if (unlock_take && !pwd_match)
				ufail_ff <= 1'b1;
			else if (st_clr && pwdata[ST_UNLOCK_FAIL])
				ufail_ff <= 1'b0;
		end
	end

	// ==========================================================
	// array program/erase gate
	// protected target: status poll only, no array strobe
	always_ff @(posedge ref_clk)
	begin
		if (rst_any)
		begin
			pe_go_ff <= 1'b0;
			pe_sect_ff <= 8'h0;
			poll_cnt_ff <= 3'h0;
			poll_ff <= 1'b0;
		end
		else
		begin
			pe_go_ff <= cmd_ok && cmd_op == OP_ARRAY_PE && !pe_prot;
			if (cmd_ok && cmd_op == OP_ARRAY_PE)
				pe_sect_ff <= 8'(cmd_sect);
			if (s_lockout)
				poll_cnt_ff <= 3'h0;
			else if (cmd_ok && cmd_op == OP_ARRAY_PE && pe_prot)
				poll_cnt_ff <= 3'(POLL_CYC);
			else if (poll_cnt_ff != 3'h0)
				poll_cnt_ff <= poll_cnt_ff - 3'h1;
			poll_ff <= !s_lockout && ((cmd_ok && cmd_op == OP_ARRAY_PE && pe_prot) || poll_cnt_ff > 3'h1); // next count not zero
		end
	end

	// ==========================================================
	// read mux
	always_comb
	begin
		rd_data = 32'h0;
		case (paddr)
			OFF_SEL: rd_data[SW-1:0] = sel_ff;
			OFF_SECT:
			begin
				rd_data[SS_VOLATILE] = vol_ff[sel_ff];
				rd_data[SS_PERSISTENT] = pers_ff[sel_ff];
				rd_data[SS_PROTECTED] = fsp_bit_prot(pers_ff[sel_ff], vol_ff[sel_ff]);
				// volatile bit only matters when persistent is 1
				rd_data[SS_WP_FORCED] = !s_wp_n && fsp_outer(sel_ff);
			end
			OFF_STATUS:
			begin
				rd_data[ST_FREEZE] = freeze_ff;
				rd_data[ST_PWD_MODE] = pwd_mode_ff;
				rd_data[ST_PERS_MODE] = pers_mode_ff;
				rd_data[ST_PROT_MODE] = prot_mode_ff;
				rd_data[ST_UNLOCK_BUSY] = unlock_cnt_ff != 8'h0;
				rd_data[ST_LOCKOUT] = s_lockout;
				rd_data[ST_WP_PIN] = s_wp_n;
				rd_data[ST_INHIBIT] = inhibit_ff;
				rd_data[ST_REFUSED] = refused_ff;
				rd_data[ST_PWD_TIMEOUT] = pwd_to_ff;
				rd_data[ST_UNLOCK_FAIL] = ufail_ff;
			end
			default:
			begin
				// password hidden once mode lock is set
				if (paddr[7:4] == OFF_PWD[7:4] && !pwd_mode_ff && prot_mode_ff)
					rd_data[15:0] = pwd_ff[wsel];
			end
		endcase
	end

	// ==========================================================
	// outputs
	logic bank_block_ff;
	// entry mode blocks the first bank only
	always_ff @(posedge ref_clk)
	begin
		if (rst_any)
			bank_block_ff <= 1'b0;
		else
			bank_block_ff <= prot_mode_ff && !s_lockout;
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign array_pe_go = pe_go_ff;
	assign array_pe_sector = pe_sect_ff;
	assign status_poll = poll_ff;
	assign first_bank_block = bank_block_ff;
	assign global_persistent_freeze = freeze_ff;

endmodule : fsp_protect

// file: fsp_protect_assertions.sv
`timescale 1ns/1ns
module fsp_protect_assertions
	import fsp_pkg::*;
#(
	parameter int N_SECT = 16
)
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic pwr_on_reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic write_protect_accel_pin_n,
	input wire logic supply_lockout_level,
	input wire logic array_pe_go,
	input wire logic [7:0] array_pe_sector,
	input wire logic status_poll,
	input wire logic first_bank_block,
	input wire logic global_persistent_freeze
);
	// ==========================================================
	// helper logic
	logic cmd_wr;
	logic outer;
	logic [2:0] lock_cnt_ff;
	logic [2:0] wp_cnt_ff;
	logic [4:0] unl_cnt_ff;
	// completed command write, and the four outer sectors
	assign cmd_wr = psel && penable && pready && pwrite && paddr == OFF_CMD;
	assign outer = array_pe_sector < 8'h02 || int'(array_pe_sector) >= N_SECT - 2;
	// pin ages saturate past the two-stage synchroniser delay
	always_ff @(posedge ref_clk)
		lock_cnt_ff <= !supply_lockout_level ? 3'h0 : lock_cnt_ff == 3'h4 ? 3'h4 : lock_cnt_ff + 3'h1;
	always_ff @(posedge ref_clk)
		wp_cnt_ff <= write_protect_accel_pin_n ? 3'h0 : wp_cnt_ff == 3'h4 ? 3'h4 : wp_cnt_ff + 3'h1;
	// cycles since the last unlock command
	always_ff @(posedge ref_clk)
		unl_cnt_ff <= reset ? 5'h1f : cmd_wr && pwdata[3:0] == OP_PWD_UNLOCK ? 5'h00 :
			unl_cnt_ff == 5'h1f ? 5'h1f : unl_cnt_ff + 5'h01;

	// ==========================================================
	// properties
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset || pwr_on_reset);
	a_ready_timing: assert property (
		psel && penable && !$past(penable) |=> pready ##1 !pready)
		else $error("pready is not a one-cycle answer");
	a_lockout_quiet: assert property (
		lock_cnt_ff == 3'h4 |-> !first_bank_block && !status_poll && (!(pready && pwrite) || pslverr))
		else $error("activity during supply lockout");
	a_poll_length: assert property (
		$rose(status_poll) |-> status_poll [*4] ##1 !status_poll)
		else $error("status poll not four cycles");
	a_go_cause: assert property (
		array_pe_go |-> $past(cmd_wr && pwdata[3:0] == OP_ARRAY_PE) && array_pe_sector == $past(pwdata[15:8]))
		else $error("go without its command");
	a_wp_outer: assert property (
		array_pe_go && wp_cnt_ff == 3'h4 |-> !outer)
		else $error("outer sector released while pin low");
	a_freeze_unlock: assert property (
		$rose(global_persistent_freeze) |-> unl_cnt_ff >= 5'h08 && unl_cnt_ff <= 5'h0c)
		else $error("freeze opened outside unlock");
	a_freeze_set: assert property (
		$fell(global_persistent_freeze) |-> $past(cmd_wr && pwdata[3:0] == OP_FREEZE_SET))
		else $error("freeze closed without command");
	a_bank_enter: assert property (
		$rose(first_bank_block) |-> $past(cmd_wr && pwdata[3:0] == OP_PROT_ENTER, 2))
		else $error("bank block without entry");
	c_poll: cover property ($rose(status_poll));
	c_go: cover property (array_pe_go);
	c_unlock: cover property ($rose(global_persistent_freeze));
endmodule : fsp_protect_assertions

bind fsp_protect fsp_protect_assertions #(.N_SECT(N_SECT)) u_fsp_chk (
	.ref_clk(ref_clk), .reset(reset), .pwr_on_reset(pwr_on_reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .write_protect_accel_pin_n(write_protect_accel_pin_n),
	.supply_lockout_level(supply_lockout_level), .array_pe_go(array_pe_go),
	.array_pe_sector(array_pe_sector), .status_poll(status_poll),
	.first_bank_block(first_bank_block), .global_persistent_freeze(global_persistent_freeze)
);

// file: fsp_protect_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) \
	begin \
		n_checks++; \
		if ((g) !== (e)) \
		begin \
			num_errors++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
		end \
	end
module fsp_protect_tb
	import fsp_pkg::*;
;
	localparam int NS = 8;
	logic ref_clk, reset, pwr_on_reset, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, array_pe_sector;
	logic [31:0] pwdata, prdata, r;
	logic wp_n, lockout, we_n, ce_n, oe_n, boot_opt, go, poll, fbb, frz;
	logic [15:0] pw [4] = '{16'h1234, 16'h5a5a, 16'h00ff, 16'hc3c3};
	int num_errors = 0;
	int n_checks = 0;
	int go_cnt = 0;

	// ==========================================================
	// clock, parts, monitors
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	fsp_protect #(.N_SECT(NS)) dut (.ref_clk(ref_clk), .reset(reset), .pwr_on_reset(pwr_on_reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .write_protect_accel_pin_n(wp_n),
		.supply_lockout_level(lockout), .we_n(we_n), .ce_n(ce_n), .oe_n(oe_n),
		.volatile_lock_boot_opt(boot_opt), .array_pe_go(go), .array_pe_sector(array_pe_sector),
		.status_poll(poll), .first_bank_block(fbb), .global_persistent_freeze(frz));
	fsp_host_model host (.ref_clk(ref_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	// go pulses last one cycle, so count them as they pass
	always @(posedge ref_clk)
		if (go === 1'b1)
			go_cnt++;

	// ==========================================================
	// helpers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		host.xfer(1'b0, a, 32'h0);
		r = host.rdata;
	endtask : rd
	task automatic cmd(input logic [3:0] op, input logic [7:0] s);
		wr(OFF_CMD, {16'h0000, s, 4'h0, op});
	endtask : cmd
	task automatic sect(input logic [7:0] s);
		wr(OFF_SEL, {24'h000000, s});
		rd(OFF_SECT);
	endtask : sect
	task automatic wait_n(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : wait_n
	task automatic do_rst(input logic por);
		@(posedge ref_clk);
		reset <= 1'b1;
		pwr_on_reset <= por;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		pwr_on_reset <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask : do_rst
	task automatic pe_try(input logic [7:0] s, input logic ok);
		int n;
		n = go_cnt;
		cmd(OP_ARRAY_PE, s);
		wait_n(2);
		`CHK(poll, !ok)
		wait_n(5);
		`CHK(go_cnt - n == 1, ok)
	endtask : pe_try

	// ==========================================================
	// scenarios
	// boot state, refusals
	task automatic t_boot;
		rd(OFF_STATUS);
		`CHK(r[ST_FREEZE], 1'b1)
		sect(8'h03);
		`CHK(r[3:0], 4'h3)
		rd(8'h30);
		`CHK({host.err, r}, {1'b1, 32'h0})
		cmd(OP_DYN_SET, 8'h02);
		rd(OFF_STATUS);
		`CHK(r[ST_REFUSED], 1'b1)
		wr(OFF_STATUS, 32'h700);
	endtask : t_boot
	task automatic t_volatile;
		cmd(OP_PROT_ENTER, 8'h00);
		wait_n(2);
		`CHK(fbb, 1'b1)
		cmd(OP_DYN_SET, 8'h02);
		sect(8'h02);
		`CHK(r[3:0], 4'h6)
		cmd(OP_DYN_CLR, 8'h02);
		sect(8'h02);
		`CHK(r[3:0], 4'h3)
	endtask : t_volatile
	task automatic t_persist;
		cmd(OP_PERS_PROG, 8'h03);
		sect(8'h03);
		`CHK(r[3:0], 4'h5)
		pe_try(8'h03, 1'b0);
		pe_try(8'h05, 1'b1);
		`CHK(array_pe_sector, 8'h05)
		// freeze only after persistent locks are set
		cmd(OP_FREEZE_SET, 8'h00);
		cmd(OP_PERS_ERASE, 8'h00);
		sect(8'h03);
		`CHK(r[1], 1'b0)
		rd(OFF_STATUS);
		`CHK({r[ST_REFUSED], r[ST_FREEZE]}, 2'b10)
		wr(OFF_STATUS, 32'h700);
		cmd(OP_PROT_EXIT, 8'h00);
		wait_n(2);
		`CHK(fbb, 1'b0)
	endtask : t_persist
	// pin guards outer sectors; pin moves only between transfers
	task automatic t_wp;
		@(posedge ref_clk);
		wp_n <= 1'b0;
		wait_n(4);
		sect(8'h00);
		`CHK(r[3:0], 4'hb)
		pe_try(8'h00, 1'b0);
		pe_try(8'(NS - 1), 1'b0);
		pe_try(8'h04, 1'b1);
		@(posedge ref_clk);
		wp_n <= 1'b1;
		wait_n(4);
		pe_try(8'h00, 1'b1);
	endtask : t_wp
	task automatic t_pwd;
		@(posedge ref_clk);
		boot_opt <= 1'b0;
		do_rst(1'b1);
		sect(8'h01);
		`CHK(r[2:0], 3'h6)
		cmd(OP_PROT_ENTER, 8'h00);
		for (int k = 0; k < 4; k++)
			wr(OFF_PWD + 8'(4 * k), {16'h0000, pw[k]});
		rd(OFF_PWD + 8'h08);
		`CHK(r[15:0], pw[2])
		wr(OFF_PWD + 8'h08, 32'hffff);
		rd(OFF_PWD + 8'h08);
		`CHK(r[15:0], pw[2])
		rd(OFF_STATUS);
		`CHK(r[ST_PWD_TIMEOUT], 1'b1)
		cmd(OP_PWD_MODE_LOCK, 8'h00);
		cmd(OP_PERS_MODE_LOCK, 8'h00);
		rd(OFF_PWD + 8'h08);
		`CHK(r, 32'h0)
		do_rst(1'b0);
		rd(OFF_STATUS);
		`CHK(r[2:0], 3'b010)
		cmd(OP_PROT_ENTER, 8'h00);
		wr(OFF_STATUS, 32'h700);
		for (int k = 0; k < 4; k++)
			wr(OFF_UBUF + 8'(4 * k), {16'h0000, pw[k] ^ 16'(k == 3)});
		// second attempt comes too soon on purpose
		cmd(OP_PWD_UNLOCK, 8'h00);
		cmd(OP_PWD_UNLOCK, 8'h00);
		wait_n(12);
		rd(OFF_STATUS);
		`CHK({r[ST_UNLOCK_FAIL], r[ST_REFUSED], r[ST_FREEZE]}, 3'b110)
		wr(OFF_STATUS, 32'h700);
		wr(OFF_UBUF + 8'h0c, {16'h0000, pw[3]});
		cmd(OP_PWD_UNLOCK, 8'h00);
		wait_n(3);
		`CHK(frz, 1'b0)
		rd(OFF_STATUS);
		`CHK({r[ST_UNLOCK_BUSY], r[ST_FREEZE]}, 2'b10)
		wait_n(4);
		`CHK(frz, 1'b0)
		wait_n(1);
		`CHK(frz, 1'b1)
	endtask : t_pwd
	task automatic t_lock;
		@(posedge ref_clk);
		lockout <= 1'b1;
		wait_n(5);
		cmd(OP_PROT_ENTER, 8'h00);
		wait_n(2);
		`CHK({host.err, fbb}, 2'b10)
		@(posedge ref_clk);
		lockout <= 1'b0;
		wait_n(4);
	endtask : t_lock
	task automatic t_inhibit;
		@(posedge ref_clk);
		we_n <= 1'b0;
		ce_n <= 1'b0;
		do_rst(1'b1);
		cmd(OP_PROT_ENTER, 8'h00);
		wait_n(2);
		`CHK({host.err, fbb}, 2'b10)
		@(posedge ref_clk);
		we_n <= 1'b1;
		wait_n(4);
		cmd(OP_PROT_ENTER, 8'h00);
		wait_n(2);
		`CHK({host.err, fbb}, 2'b01)
	endtask : t_inhibit

	// ==========================================================
	// sequence, watchdog, verdict
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	initial
	begin
		reset = 1'b1;
		pwr_on_reset = 1'b1;
		wp_n = 1'b1;
		lockout = 1'b0;
		we_n = 1'b1;
		ce_n = 1'b1;
		oe_n = 1'b1;
		boot_opt = 1'b1;
		do_rst(1'b1);
		t_boot();
		t_volatile();
		t_persist();
		t_wp();
		t_pwd();
		t_lock();
		t_inhibit();
		end_sim();
	end
	// the tests need well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		num_errors++;
		end_sim();
	end
endmodule : fsp_protect_tb

// file: fsp_tail.sv
`timescale 1ns/1ns
